// >>> hdl/apt_regs.svh
// register offsets, field positions, reset values and timing counts
// for the pair trigger sequencer; definitions only
`ifndef APT_REGS_SVH
`define APT_REGS_SVH

// ============================================================
// register offsets (byte addresses on the plain register port)
`define APT_OFS_PAIR_CTRL   8'h00
`define APT_OFS_CONFIG      8'h04
`define APT_OFS_RES_AN4     8'h08
`define APT_OFS_RES_AN5     8'h0c
`define APT_OFS_RES_AN6     8'h10
`define APT_OFS_RES_AN7     8'h14
`define APT_OFS_STATUS      8'h18

// ============================================================
// pair control fields: pair 3 in the high byte, pair 2 in the low
`define APT_P3_IRQ_EN_BIT   15
`define APT_P3_PEND_BIT     14
`define APT_P3_SWTRG_BIT    13
`define APT_P3_SEL_MSB      12
`define APT_P3_SEL_LSB      8
`define APT_P2_IRQ_EN_BIT   7
`define APT_P2_PEND_BIT     6
`define APT_P2_SWTRG_BIT    5
`define APT_P2_SEL_MSB      4
`define APT_P2_SEL_LSB      0

// config fields
`define APT_CFG_ON_BIT      0
`define APT_CFG_GTRG_BIT    1
`define APT_CFG_DIV_MSB     11
`define APT_CFG_DIV_LSB     8

// ============================================================
// reset values
`define APT_PAIR_CTRL_RST   16'h0000
`define APT_DIV_RST         4'h0

// ============================================================
// trigger source codes
`define APT_TRG_NONE        5'h00
`define APT_TRG_SOFT        5'h01
`define APT_TRG_GLOBAL      5'h02
`define APT_TRG_SPECIAL     5'h03
`define APT_TRG_GEN_FIRST   5'h04
`define APT_TRG_GEN_LAST    5'h07
`define APT_TRG_TMR1        5'h0c
`define APT_TRG_TMR2        5'h0d
`define APT_TRG_CL_FIRST    5'h0e
`define APT_TRG_CL_LAST     5'h11
`define APT_TRG_FLT_FIRST   5'h16
`define APT_TRG_FLT_LAST    5'h19

// ============================================================
// timing in converter clock periods
`define APT_SAMPLE_TADS     4'd2
`define APT_CONV_TADS       4'd10

`endif

// >>> hdl/apt_pkg.sv
// types shared by the pair trigger sequencer modules
// assumes nothing beyond a systemverilog compiler
package apt_pkg;

  // ============================================================
  // converter core states
  typedef enum logic [2:0] {
    APT_CV_IDLE    = 3'b001,
    APT_CV_SAMPLE  = 3'b010,
    APT_CV_CONVERT = 3'b100
  } apt_cv_state_t;

endpackage : apt_pkg

// >>> hdl/apt_trig_mux.sv
// trigger source selector for one channel pair
// assumes every trigger input is a one-cycle pulse on clk
`timescale 1ns/1ps
`include "apt_regs.svh"

module apt_trig_mux
  import apt_pkg::*;
(
  input  wire logic [4:0] sel,          // trigger source code
  input  wire logic       soft_trig,    // individual software trigger
  input  wire logic       global_trig,  // global software trigger
  input  wire logic       special_trig, // pwm special event
  input  wire logic [3:0] gen_trig,     // pwm generator triggers
  input  wire logic       tmr1_match,   // timer one period match
  input  wire logic       tmr2_match,   // timer two period match
  input  wire logic [3:0] cl_trig,      // current-limit triggers
  input  wire logic [3:0] flt_trig,     // fault triggers
  output logic            hit           // selected trigger asserted
);

  // ============================================================
  // range lookup: index of a code inside a four-wide group
  function automatic logic in_group(input logic [4:0] code,
                                    input logic [4:0] first,
                                    input logic [3:0] vec);
    logic [4:0] ofs;
    ofs = code - first;
    in_group = (ofs < 5'd4) && vec[ofs[1:0]];
  endfunction : in_group

  always_comb begin
    hit = 1'b0;
    unique case (sel)
      `APT_TRG_NONE:    hit = 1'b0;
      `APT_TRG_SOFT:    hit = soft_trig;
      `APT_TRG_GLOBAL:  hit = global_trig;
      `APT_TRG_SPECIAL: hit = special_trig;
      `APT_TRG_TMR1:    hit = tmr1_match;
      `APT_TRG_TMR2:    hit = tmr2_match;
      default: begin
        // unassigned codes fall through all groups to no trigger
        hit = in_group(sel, `APT_TRG_GEN_FIRST, gen_trig)
            | in_group(sel, `APT_TRG_CL_FIRST, cl_trig)
            | in_group(sel, `APT_TRG_FLT_FIRST, flt_trig);
      end
    endcase
  end

endmodule : apt_trig_mux

// >>> hdl/apt_converter.sv
// successive approximation core for one pair of channels
// assumes tick is a one-cycle pulse per converter clock period
`timescale 1ns/1ps
`include "apt_regs.svh"

module apt_converter
  import apt_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input  wire logic             clk,    // system clock
  input  wire logic             rst_n,  // synchronised reset, active low
  input  wire logic             tick,   // converter clock period pulse
  input  wire logic             start,  // begin sample then convert
  input  wire logic [WIDTH-1:0] samp_a, // held level, even channel
  input  wire logic [WIDTH-1:0] samp_b, // held level, odd channel
  output logic                  busy,   // sampling or converting
  output logic                  done,   // one-cycle completion pulse
  output logic      [WIDTH-1:0] res_a,  // finished result, even
  output logic      [WIDTH-1:0] res_b   // finished result, odd
);

  apt_cv_state_t    state_reg, state_next;
  logic [3:0]       cnt_reg, cnt_next;
  logic [WIDTH-1:0] in_a_reg, in_a_next, in_b_reg, in_b_next;
  logic [WIDTH-1:0] sar_a_reg, sar_a_next, sar_b_reg, sar_b_next;
  logic [WIDTH-1:0] res_a_reg, res_a_next, res_b_reg, res_b_next;
  logic             done_reg, done_next;
  logic [WIDTH-1:0] bit_mask;

  // keep the trial bit when the trial code does not exceed the input
  function automatic logic [WIDTH-1:0] sar_step(
    input logic [WIDTH-1:0] acc, input logic [WIDTH-1:0] msk,
    input logic [WIDTH-1:0] level);
    sar_step = ((acc | msk) <= level) ? (acc | msk) : acc;
  endfunction : sar_step

  // cnt counts down the remaining bit positions, msb first
  assign bit_mask = WIDTH'(1) << (cnt_reg - 4'd1);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    in_a_next  = in_a_reg;
    in_b_next  = in_b_reg;
    sar_a_next = sar_a_reg;
    sar_b_next = sar_b_reg;
    res_a_next = res_a_reg;
    res_b_next = res_b_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      APT_CV_IDLE: begin
        if (start) begin
          state_next = APT_CV_SAMPLE;
          cnt_next   = `APT_SAMPLE_TADS;
          in_a_next  = samp_a;
          in_b_next  = samp_b;
        end
      end
      APT_CV_SAMPLE: begin
        if (tick) begin
          cnt_next = cnt_reg - 4'd1;
          if (cnt_reg == 4'd1) begin
            state_next = APT_CV_CONVERT;
            cnt_next   = `APT_CONV_TADS;
            sar_a_next = '0;
            sar_b_next = '0;
          end
        end
      end
      APT_CV_CONVERT: begin
        if (tick) begin
          // one bit per converter clock, bit 9 down to bit 0
          sar_a_next = sar_step(sar_a_reg, bit_mask, in_a_reg);
          sar_b_next = sar_step(sar_b_reg, bit_mask, in_b_reg);
          cnt_next   = cnt_reg - 4'd1;
          if (cnt_reg == 4'd1) begin
            state_next = APT_CV_IDLE;
            res_a_next = sar_a_next;
            res_b_next = sar_b_next;
            done_next  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= APT_CV_IDLE;
      cnt_reg   <= 4'h0;
      in_a_reg  <= '0;
      in_b_reg  <= '0;
      sar_a_reg <= '0;
      sar_b_reg <= '0;
      res_a_reg <= '0;
      res_b_reg <= '0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      in_a_reg  <= in_a_next;
      in_b_reg  <= in_b_next;
      sar_a_reg <= sar_a_next;
      sar_b_reg <= sar_b_next;
      res_a_reg <= res_a_next;
      res_b_reg <= res_b_next;
      done_reg  <= done_next;
    end
  end

  assign busy  = (state_reg != APT_CV_IDLE);
  assign done  = done_reg;
  assign res_a = res_a_reg;
  assign res_b = res_b_reg;

endmodule : apt_converter

// >>> hdl/apt_sequencer.sv
// pair trigger sequencer top: registers, trigger capture, pending
// tracking and scheduling of the shared converter core
// assumes all inputs are synchronous to clk and triggers are pulses
`timescale 1ns/1ps
`include "apt_regs.svh"

// Notes on behaviour
// - control register packs pair 3 high, pair 2 low
// - completion pulses irq only when pair enabled
// - trigger sets pending, completion clears it
// - soft trigger bit starts, cleared when pending sets
// - busy converter defers triggered pair's conversion
// - code zero accepts no trigger
// - codes 1 and 2 select software triggers
// - code 3 special event, 4-7 generators
// - codes 12 and 13 select timer matches
// - codes 14-17 select current-limit triggers
// - codes 22-25 select fault triggers
// - sampling lasts exactly two converter clocks
// - trigger starts sample, conversion when free
// - trigger on pending pair is dropped
// - conversion takes ten more converter clocks
// - result resolved msb first, bit 9 down
// - result register written only on completion
module apt_sequencer
  import apt_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int NPAIR = 2
) (
  input  wire logic             clk,              // 100 MHz clock
  input  wire logic             resetn,           // async reset, low
  input  wire logic [7:0]       reg_addr,         // register byte address
  input  wire logic [15:0]      reg_wdata,        // write data
  input  wire logic             reg_wr,           // write strobe
  input  wire logic             reg_rd,           // read strobe
  output logic      [15:0]      reg_rdata,        // read data, next cycle
  input  wire logic [WIDTH-1:0] analog_input_4,   // pair 2 even channel
  input  wire logic [WIDTH-1:0] analog_input_5,   // pair 2 odd channel
  input  wire logic [WIDTH-1:0] analog_input_6,   // pair 3 even channel
  input  wire logic [WIDTH-1:0] analog_input_7,   // pair 3 odd channel
  input  wire logic             pwm_special_trig, // special event pulse
  input  wire logic [3:0]       pwm_gen_trig,     // generator pulses
  input  wire logic             timer1_match,     // timer one period
  input  wire logic             timer2_match,     // timer two period
  input  wire logic [3:0]       pwm_cl_trig,      // current-limit pulses
  input  wire logic [3:0]       pwm_flt_trig,     // fault pulses
  output logic                  pair2_irq,        // pair 2 done pulse
  output logic                  pair3_irq,        // pair 3 done pulse
  output logic                  converter_busy    // conversion underway
);

  // ============================================================
  // reset release
  // retimed so every flop leaves reset on the same edge
  logic rst_meta_reg, rst_sync_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // ============================================================
  // register state
  // pending is set and cleared by hardware only
  // the soft trigger bit is a level the hardware clears
  logic [NPAIR-1:0] irq_en_reg, irq_en_next;
  logic [NPAIR-1:0] pend_reg, pend_next;
  logic [NPAIR-1:0] swtrg_reg, swtrg_next;
  logic [4:0]       sel_reg [NPAIR];
  logic [4:0]       sel_next [NPAIR];
  logic             on_reg, on_next;
  logic [3:0]       div_reg, div_next;
  logic             gtrg_reg, gtrg_next;
  logic [15:0]      rdata_reg, rdata_next;

  // ============================================================
  // scheduling state
  // levels are held per pair from trigger to start
  logic [3:0]       tick_cnt_reg, tick_cnt_next;
  logic             tick_reg, tick_next;
  logic [WIDTH-1:0] hold_a_reg [NPAIR];
  logic [WIDTH-1:0] hold_a_next [NPAIR];
  logic [WIDTH-1:0] hold_b_reg [NPAIR];
  logic [WIDTH-1:0] hold_b_next [NPAIR];
  logic [WIDTH-1:0] res_a_reg [NPAIR];
  logic [WIDTH-1:0] res_a_next [NPAIR];
  logic [WIDTH-1:0] res_b_reg [NPAIR];
  logic [WIDTH-1:0] res_b_next [NPAIR];
  logic             in_conv_reg, in_conv_next;
  logic             active_reg, active_next;
  logic             start_reg, start_next;
  logic [WIDTH-1:0] samp_a_reg, samp_a_next, samp_b_reg, samp_b_next;
  logic [NPAIR-1:0] irq_reg, irq_next;
  logic             busy_reg, busy_next;

  logic [NPAIR-1:0] hit, accept;
  logic [WIDTH-1:0] in_a [NPAIR];
  logic [WIDTH-1:0] in_b [NPAIR];
  logic             cv_busy, cv_done;
  logic [WIDTH-1:0] cv_res_a, cv_res_b;
  logic             wr_ctrl, wr_cfg;

  // index 0 is pair 2 (inputs 4, 5), index 1 is pair 3
  assign in_a[0] = analog_input_4;
  assign in_b[0] = analog_input_5;
  assign in_a[1] = analog_input_6;
  assign in_b[1] = analog_input_7;
  assign wr_ctrl = reg_wr && (reg_addr == `APT_OFS_PAIR_CTRL);
  assign wr_cfg  = reg_wr && (reg_addr == `APT_OFS_CONFIG);

  // ============================================================
  // trigger selection, one selector per pair
  // all pairs see the same lines; only the code and the soft trigger bit differ
  for (genvar p = 0; p < NPAIR; p++) begin : g_mux
    apt_trig_mux u_mux (
      .sel          (sel_reg[p]),
      .soft_trig    (swtrg_reg[p]),
      .global_trig  (gtrg_reg),
      .special_trig (pwm_special_trig),
      .gen_trig     (pwm_gen_trig),
      .tmr1_match   (timer1_match),
      .tmr2_match   (timer2_match),
      .cl_trig      (pwm_cl_trig),
      .flt_trig     (pwm_flt_trig),
      .hit          (hit[p])
    );
  end

  // a trigger while the pair is still pending is simply dropped
  // and one with the converter off is ignored as well
  assign accept = hit & ~pend_reg & {NPAIR{on_reg}};

  // ============================================================
  // register file
  // reads mirror the write layout; pending is read-only
  function automatic logic [15:0] pack_ctrl(
    input logic [NPAIR-1:0] en, input logic [NPAIR-1:0] pd,
    input logic [NPAIR-1:0] sw, input logic [4:0] s3,
    input logic [4:0] s2);
    pack_ctrl = {en[1], pd[1], sw[1], s3,
                 en[0], pd[0], sw[0], s2};
  endfunction : pack_ctrl

  always_comb begin
    irq_en_next = irq_en_reg;
    swtrg_next  = swtrg_reg;
    sel_next    = sel_reg;
    on_next     = on_reg;
    div_next    = div_reg;
    gtrg_next   = wr_cfg && reg_wdata[`APT_CFG_GTRG_BIT];
    rdata_next  = 16'h0000;
    if (wr_ctrl) begin
      irq_en_next[1] = reg_wdata[`APT_P3_IRQ_EN_BIT];
      irq_en_next[0] = reg_wdata[`APT_P2_IRQ_EN_BIT];
      sel_next[1] = reg_wdata[`APT_P3_SEL_MSB:`APT_P3_SEL_LSB];
      sel_next[0] = reg_wdata[`APT_P2_SEL_MSB:`APT_P2_SEL_LSB];
    end
    for (int p = 0; p < NPAIR; p++) begin
      // a software write of one beats the hardware clear
      if (accept[p]) begin
        swtrg_next[p] = 1'b0;
      end else if (hit[p] && (pend_reg[p] || !on_reg)) begin
        // a request that cannot be taken is dropped, not kept
        swtrg_next[p] = 1'b0;
      end
    end
    if (wr_ctrl) begin
      swtrg_next[1] = reg_wdata[`APT_P3_SWTRG_BIT];
      swtrg_next[0] = reg_wdata[`APT_P2_SWTRG_BIT];
    end
    if (wr_cfg) begin
      on_next  = reg_wdata[`APT_CFG_ON_BIT];
      // divisor is trusted to change only while off
      div_next = reg_wdata[`APT_CFG_DIV_MSB:`APT_CFG_DIV_LSB];
    end
    // read data stand one cycle, zero otherwise
    if (reg_rd) begin
      unique case (reg_addr)
        `APT_OFS_PAIR_CTRL: rdata_next = pack_ctrl(irq_en_reg,
            pend_reg, swtrg_reg, sel_reg[1], sel_reg[0]);
        `APT_OFS_CONFIG:  rdata_next = {4'h0, div_reg, 7'h00, on_reg};
        `APT_OFS_RES_AN4: rdata_next = 16'(res_a_reg[0]);
        `APT_OFS_RES_AN5: rdata_next = 16'(res_b_reg[0]);
        `APT_OFS_RES_AN6: rdata_next = 16'(res_a_reg[1]);
        `APT_OFS_RES_AN7: rdata_next = 16'(res_b_reg[1]);
        `APT_OFS_STATUS:  rdata_next = {14'h0000, active_reg, busy_reg};
        default:          rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= '0;
      swtrg_reg  <= '0;
      sel_reg    <= '{default: `APT_TRG_NONE};
      on_reg     <= 1'b0;
      div_reg    <= `APT_DIV_RST;
      gtrg_reg   <= 1'b0;
      rdata_reg  <= 16'h0000;
    end else begin
      irq_en_reg <= irq_en_next;
      swtrg_reg  <= swtrg_next;
      sel_reg    <= sel_next;
      on_reg     <= on_next;
      div_reg    <= div_next;
      gtrg_reg   <= gtrg_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ============================================================
  // converter clock: one tick every div+1 system clocks while on
  // the count sits at zero while off, so the first tick after
  // switch-on is a full period late and a frozen core stays put
  always_comb begin
    tick_cnt_next = 4'h0;
    tick_next     = 1'b0;
    if (on_reg) begin
      if (tick_cnt_reg >= div_reg) begin
        tick_next = 1'b1;
      end else begin
        tick_cnt_next = tick_cnt_reg + 4'd1;
      end
    end
  end

  // ============================================================
  // pending, hold and scheduling
  always_comb begin
    pend_next    = pend_reg;
    hold_a_next  = hold_a_reg;
    hold_b_next  = hold_b_reg;
    res_a_next   = res_a_reg;
    res_b_next   = res_b_reg;
    in_conv_next = in_conv_reg;
    active_next  = active_reg;
    start_next   = 1'b0;
    samp_a_next  = samp_a_reg;
    samp_b_next  = samp_b_reg;
    irq_next     = '0;
    busy_next    = in_conv_reg || cv_busy;
    for (int p = 0; p < NPAIR; p++) begin
      if (accept[p]) begin
        // inputs are caught at the trigger so the sample point
        // does not drift with converter availability
        pend_next[p]   = 1'b1;
        hold_a_next[p] = in_a[p];
        hold_b_next[p] = in_b[p];
      end
    end
    // completion and a new start never share a cycle; the next
    // pending pair starts one cycle after the core is freed
    if (cv_done) begin
      pend_next[active_reg]  = 1'b0;
      res_a_next[active_reg] = cv_res_a;
      res_b_next[active_reg] = cv_res_b;
      irq_next[active_reg]   = irq_en_reg[active_reg];
      in_conv_next = 1'b0;
    end else if (!in_conv_reg && (pend_reg != '0)) begin
      // one converter core: other pending pairs wait here
      in_conv_next = 1'b1;
      active_next  = !pend_reg[0];
      start_next   = 1'b1;
      samp_a_next  = hold_a_reg[!pend_reg[0]];
      samp_b_next  = hold_b_reg[!pend_reg[0]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 4'h0;
      tick_reg     <= 1'b0;
      pend_reg     <= '0;
      hold_a_reg   <= '{default: '0};
      hold_b_reg   <= '{default: '0};
      res_a_reg    <= '{default: '0};
      res_b_reg    <= '{default: '0};
      in_conv_reg  <= 1'b0;
      active_reg   <= 1'b0;
      start_reg    <= 1'b0;
      samp_a_reg   <= '0;
      samp_b_reg   <= '0;
      irq_reg      <= '0;
      busy_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
      pend_reg     <= pend_next;
      hold_a_reg   <= hold_a_next;
      hold_b_reg   <= hold_b_next;
      res_a_reg    <= res_a_next;
      res_b_reg    <= res_b_next;
      in_conv_reg  <= in_conv_next;
      active_reg   <= active_next;
      start_reg    <= start_next;
      samp_a_reg   <= samp_a_next;
      samp_b_reg   <= samp_b_next;
      irq_reg      <= irq_next;
      busy_reg     <= busy_next;
    end
  end

  // ============================================================
  // shared converter core
  // one core only, so pairs are served strictly one at a time
  // throughput is not policed; over-rate triggers are only dropped
  // while pending
  apt_converter #(
    .WIDTH (WIDTH)
  ) u_conv (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick   (tick_reg),
    .start  (start_reg),
    .samp_a (samp_a_reg),
    .samp_b (samp_b_reg),
    .busy   (cv_busy),
    .done   (cv_done),
    .res_a  (cv_res_a),
    .res_b  (cv_res_b)
  );

  // ============================================================
  // outputs
  // every output is a register, nothing combinational leaves
  assign reg_rdata      = rdata_reg;
  assign pair2_irq      = irq_reg[0];
  assign pair3_irq      = irq_reg[1];
  assign converter_busy = busy_reg;

endmodule : apt_sequencer

// >>> tb/apt_seq_props.sv
// port-level assertions for the pair trigger sequencer
// assumes it is bound into apt_sequencer and sees only its ports
`timescale 1ns/1ps
module apt_seq_props (
  input wire logic        clk,           // clock
  input wire logic        resetn,        // reset, low
  input wire logic        reg_rd,        // read strobe
  input wire logic [15:0] reg_rdata,     // read data
  input wire logic        pair2_irq,     // pair 2 done
  input wire logic        pair3_irq,     // pair 3 done
  input wire logic        converter_busy // busy
);
  // ====
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic irq = pair2_irq | pair3_irq;
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  property p_one_pair; !(pair2_irq && pair3_irq); endproperty
  a_one_pair: assert property (p_one_pair)
    else $error("both pairs done together");
  property p_irq2_cause; pair2_irq |-> $past(converter_busy); endproperty
  a_irq2_cause: assert property (p_irq2_cause)
    else $error("pair 2 done without conversion");
  property p_irq3_cause; pair3_irq |-> $past(converter_busy); endproperty
  a_irq3_cause: assert property (p_irq3_cause)
    else $error("pair 3 done without conversion");
  // each conversion spends 12 ticks, so two completions sit far apart
  property p_irq_gap; irq |=> !irq [*8]; endproperty
  a_irq_gap: assert property (p_irq_gap)
    else $error("completions too close");
  property p_busy_min; $rose(converter_busy) |=> converter_busy [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("conversion too short");
  property p_done_bound;
    $rose(converter_busy) |-> ##[12:600] !converter_busy;
  endproperty
  a_done_bound: assert property (p_done_bound)
    else $error("conversion never completed");
  property p_irq_pulse; pair2_irq |=> !pair2_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("pair 2 done held");
  c_p2: cover property (pair2_irq);
  c_p3: cover property (pair3_irq);
  c_both: cover property (pair2_irq ##[1:40] pair3_irq);
endmodule : apt_seq_props

bind apt_sequencer apt_seq_props u_props (.clk(clk), .resetn(resetn),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair2_irq(pair2_irq),
  .pair3_irq(pair3_irq), .converter_busy(converter_busy));

// >>> tb/apt_trig_model.sv
// trigger sources beside the sequencer: pwm, timers, limits, faults
// assumes fire or all is a one-cycle request from the bench
`timescale 1ns/1ps
module apt_trig_model (
  input  wire logic       clk,  // clock
  input  wire logic       fire, // pulse line chosen by code
  input  wire logic       all,  // pulse every line
  input  wire logic [4:0] code, // source code
  output logic            sp,   // special event
  output logic      [3:0] gen,  // generators
  output logic            t1,   // timer one
  output logic            t2,   // timer two
  output logic      [3:0] cl,   // current limit
  output logic      [3:0] flt   // fault
);
  // ====
  // one-cycle pulses; bench repeats one request while the pair is still pending
  initial {sp, gen, t1, t2, cl, flt} = 15'h0000;
  always @(posedge clk) begin
    sp  <= all | (fire && code == 5'h03);
    gen <= {4{all}} | ((fire && code >= 5'h04 && code <= 5'h07) ?
           4'h1 << (code - 5'h04) : 4'h0);
    t1  <= all | (fire && code == 5'h0c);
    t2  <= all | (fire && code == 5'h0d);
    cl  <= {4{all}} | ((fire && code >= 5'h0e && code <= 5'h11) ?
           4'h1 << (code - 5'h0e) : 4'h0);
    flt <= {4{all}} | ((fire && code >= 5'h16 && code <= 5'h19) ?
           4'h1 << (code - 5'h16) : 4'h0);
  end
endmodule : apt_trig_model

// >>> tb/testbench.sv
// self-checking bench for apt_sequencer with a queue model of completions
// assumes the trigger model and the bound checker are compiled alongside
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic        fire = 0, fall = 0, sp, t1, t2, p2i, p3i, busy;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [9:0]  an4 = 0, an5 = 0, an6 = 0, an7 = 0;
  logic [3:0]  gen, cl, flt;
  logic [4:0]  code = 0;
  int num_errors = 0, check_count = 0, seed = 32'h575f, cyc = 0;
  int codes[$] = '{1,2,3,4,5,6,7,12,13,14,15,16,17,22,23,24,25};
  int exp_q[$];
  apt_sequencer dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .analog_input_4(an4), .analog_input_5(an5),
    .analog_input_6(an6), .analog_input_7(an7), .pwm_special_trig(sp),
    .pwm_gen_trig(gen), .timer1_match(t1), .timer2_match(t2),
    .pwm_cl_trig(cl), .pwm_flt_trig(flt), .pair2_irq(p2i),
    .pair3_irq(p3i), .converter_busy(busy));
  apt_trig_model u_src (.clk(clk), .fire(fire), .all(fall), .code(code),
    .sp(sp), .gen(gen), .t1(t1), .t2(t2), .cl(cl), .flt(flt));
  // ====
  // tasks
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (e !== g) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) begin reg_rd <= 1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 0;
    #1 chk("read data", e, reg_rdata);
  endtask : rd
  task automatic trig(input logic [4:0] c, input logic a);
    @(posedge clk) begin fire <= !a; fall <= a; code <= c; end
    @(posedge clk) begin fire <= 0; fall <= 0; end
  endtask : trig
  // a request on a pair already queued is dropped, as the device must
  task automatic mt(input int p);
    if (!(p inside {exp_q})) exp_q.push_back(p);
  endtask : mt
  task automatic count_irq(input int n);
    int e;
    repeat (n) @(negedge clk) if (p2i || p3i) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 0;
      chk("irq pair", 16'(e), p3i ? 16'h0003 : 16'h0002);
    end
    chk("irq left", 16'h0000, 16'(exp_q.size()));
  endtask : count_irq
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // ====
  // clock, timeout, sequence
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin num_errors++; print_verdict(); end
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    repeat (4) @(posedge clk);
    rd(8'h00, 16'h0000);
    rd(8'h1c, 16'h0000);
    wr(8'h04, 16'h0001);
    foreach (codes[i]) begin
      an4 <= 10'($random(seed));
      an5 <= 10'($random(seed));
      wr(8'h00, 16'h0080 | 16'(codes[i]) | (codes[i] == 1 ? 16'h0020 : 0));
      if (codes[i] == 2) wr(8'h04, 16'h0003);
      else if (codes[i] > 2) trig(5'(codes[i]), 0);
      mt(2);
      count_irq(40);
      rd(8'h08, {6'h00, an4});
      rd(8'h0c, {6'h00, an5});
      rd(8'h00, 16'h0080 | 16'(codes[i]));
    end
    wr(8'h00, 16'h0008);
    trig(5'h00, 1);
    wr(8'h04, 16'h0003);
    count_irq(40);
    rd(8'h00, 16'h0008);
    an6 <= 10'($random(seed));
    an7 <= 10'($random(seed));
    wr(8'h00, 16'h8383);
    trig(5'h03, 0);
    mt(2);
    mt(3);
    trig(5'h03, 0);
    mt(2);
    count_irq(80);
    rd(8'h10, {6'h00, an6});
    rd(8'h14, {6'h00, an7});
    rd(8'h18, 16'h0002);
    wr(8'h04, 16'h0000);
    wr(8'h04, 16'h0101);
    rd(8'h04, 16'h0101);
    wr(8'h00, 16'h0303);
    trig(5'h03, 0);
    count_irq(80);
    rd(8'h00, 16'h0303);
    print_verdict();
  end
endmodule : testbench
